// ---- fsp_port_map.vh ----
// Functional notes
// - the port has five two-way pins shared with four low area selects, a low refresh strobe and four low interrupt inputs.
// - expanded modes 1 to 5 add area selects, refresh strobe and interrupt inputs; single-chip modes 6 and 7 add only the interrupt inputs.
// - an 8-bit write-only direction register has bits 4 to 0, each choosing input or output for one pin.
// - every read of the direction register outside hardware standby returns all ones; in hardware standby a read gets an error and zero.
// - reset and hardware standby load the direction register with f0 in modes 1 to 4 and e0 in modes 5 to 7, bits 7 to 5 at one.
// - software standby keeps the direction register and every pin set as output keeps driving.
// - in expanded modes direction bits 4 to 1 make pins 4 to 1 area select outputs and bit 0 makes pin 0 an output; a clear bit makes an input.
// - in single-chip modes each pin is plain i/o, output when its direction bit is one, input when zero.
// - an 8-bit read/write data register holds in bits 4 to 0 the output values for pins 4 to 0.
// - a data read returns the stored bit where the direction bit is one and the pin level where it is zero.
// - data bits 7 to 5 ignore writes and read one outside hardware standby, where a read gets an error and zero.
// - reset and hardware standby set the data register to e0; software standby leaves it unchanged.
`ifndef FSP_PORT_MAP_VH
`define FSP_PORT_MAP_VH

// register indices as printed, byte address is four times the index
`define FSP_IDX_DIR       16'hffcd
`define FSP_IDX_DATA      16'hffcf
`define FSP_ADDR_W        18
`define FSP_ADDR_DIR      18'h3_ff34
`define FSP_ADDR_DATA     18'h3_ff3c

// field layout
`define FSP_PINS          5
`define FSP_PIN_MSB       4
`define FSP_RSV_MSB       7
`define FSP_RSV_LSB       5
`define FSP_BIT_SEL0      4

// reset values
`define FSP_DIR_RST_LOW   8'hf0
`define FSP_DIR_RST_HIGH  8'he0
`define FSP_DATA_RST      8'he0
`define FSP_RSV_ONES      3'h7
`define FSP_DIR_READ      8'hff

// operating modes
`define FSP_MODE_1        3'h1
`define FSP_MODE_4        3'h4
`define FSP_MODE_6        3'h6
`define FSP_MODE_7        3'h7

// cycles after reset release before the mode strap is settled
`define FSP_INIT_CYCLES   3'h4

`endif

// ---- fsp_pin_sync.v ----
`timescale 1ns/100ps
// three-stage input synchroniser, output follows once stages two and three agree
module fsp_pin_sync #(
    parameter W       = 1,
    parameter RST_VAL = 1'b0
) (
    input  wire         mclk,
    input  wire         reset,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    integer     i;

    // first stage feeds only the second
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            s1_ff <= {W{RST_VAL}};
            s2_ff <= {W{RST_VAL}};
            s3_ff <= {W{RST_VAL}};
            dout  <= {W{RST_VAL}};
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    dout[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule // fsp_pin_sync

// ---- fsp_port.v ----
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`include "fsp_port_map.vh"
// five-pin shared i/o port with apb register access
module fsp_port (
    input  wire                   mclk,
    input  wire                   reset,
    // operating mode strap and standby controls
    input  wire [2:0]             mode,
    input  wire                   hw_standby,
    input  wire                   sw_standby,
    // apb slave
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`FSP_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    output reg  [31:0]            prdata,
    output reg                    pready,
    output reg                    pslverr,
    // alternate functions from bus and refresh controllers, interrupt requests out to the controller
    input  wire [3:0]             area_select_n,
    input  wire                   refresh_strobe_n,
    input  wire                   refresh_enable,
    output wire [3:0]             ext_irq_request_n,
    // pins
    input  wire [4:0]             pin_in,
    output reg  [4:0]             pin_out,
    output reg  [4:0]             pin_oe
);
    // settled inputs
    wire [4:0] pin_sync;
    wire [2:0] mode_sync;
    wire       hw_stby_sync;
    wire       sw_stby_sync;

    // registers
    reg  [7:0] pin_direction_ff;
    reg  [7:0] pin_data_ff;
    reg  [2:0] mode_ff;
    reg  [2:0] init_cnt_ff;
    reg        init_done_ff;

    // next values
    reg  [7:0] nxt_pin_direction;
    reg  [7:0] nxt_pin_data;
    reg  [4:0] nxt_pin_out;
    reg  [4:0] nxt_pin_oe;
    reg  [31:0] nxt_prdata;
    reg        nxt_pslverr;

    // decode
    wire       expanded;
    wire       low_dir_modes;
    wire       hit_dir;
    wire       hit_data;
    wire       access;
    wire       complete;
    wire [7:0] dir_init;
    wire [7:0] data_read;
    integer    i;

    // pin levels, interrupt inputs included
    fsp_pin_sync #(
        .W       (5),
        .RST_VAL (1'b1)
    ) u_pin_sync (
        .mclk  (mclk),
        .reset (reset),
        .din   (pin_in),
        .dout  (pin_sync)
    );

    // mode strap
    fsp_pin_sync #(
        .W       (3),
        .RST_VAL (1'b0)
    ) u_mode_sync (
        .mclk  (mclk),
        .reset (reset),
        .din   (mode),
        .dout  (mode_sync)
    );

    // standby controls
    fsp_pin_sync #(
        .W       (2),
        .RST_VAL (1'b0)
    ) u_stby_sync (
        .mclk  (mclk),
        .reset (reset),
        .din   ({hw_standby, sw_standby}),
        .dout  ({hw_stby_sync, sw_stby_sync})
    );

    // interrupt requests reach the controller in every mode
    assign ext_irq_request_n = pin_sync[3:0];

    // mode classes
    assign expanded      = (mode_ff != `FSP_MODE_6) && (mode_ff != `FSP_MODE_7);
    assign low_dir_modes = (mode_ff >= `FSP_MODE_1) && (mode_ff <= `FSP_MODE_4);
    assign dir_init      = low_dir_modes ? `FSP_DIR_RST_LOW : `FSP_DIR_RST_HIGH;

    // apb decode, one wait state from registered pready
    assign hit_dir  = (paddr == `FSP_ADDR_DIR);
    assign hit_data = (paddr == `FSP_ADDR_DATA);
    assign access   = psel && penable && !pready && init_done_ff;
    assign complete = psel && penable && pready;

    // per-bit read mux, reserved bits forced high
    assign data_read = {`FSP_RSV_ONES,
                        (pin_direction_ff[4:0] & pin_data_ff[4:0]) |
                        (~pin_direction_ff[4:0] & pin_sync)};

    // mode strap caught once the synchroniser has settled after release
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            init_cnt_ff  <= 3'h0;
            init_done_ff <= 1'b0;
            mode_ff      <= `FSP_MODE_7;
        end else if (!init_done_ff) begin
            if (init_cnt_ff == `FSP_INIT_CYCLES) begin
                init_done_ff <= 1'b1;
                mode_ff      <= mode_sync;
            end else begin
                init_cnt_ff <= init_cnt_ff + 3'h1;
            end
        end
    end

    // register next values
    always @* begin
        nxt_pin_direction = pin_direction_ff;
        nxt_pin_data      = pin_data_ff;
        if (!init_done_ff) begin
            // mode-dependent initial direction, reset value
            nxt_pin_direction = (init_cnt_ff == `FSP_INIT_CYCLES) ?
                                ((mode_sync >= `FSP_MODE_1 && mode_sync <= `FSP_MODE_4) ?
                                 `FSP_DIR_RST_LOW : `FSP_DIR_RST_HIGH) :
                                `FSP_DIR_RST_HIGH;
            nxt_pin_data      = `FSP_DATA_RST;
        end else if (hw_stby_sync) begin
            // hardware standby re-initialises both registers
            nxt_pin_direction = dir_init;
            nxt_pin_data      = `FSP_DATA_RST;
        end else if (complete && pwrite && !pslverr) begin
            // software standby takes no special path, contents kept
            if (hit_dir) begin
                // write-only direction bits 4..0, reserved stay one
                nxt_pin_direction = {`FSP_RSV_ONES, pwdata[4:0]};
            end
            if (hit_data) begin
                // data bits 4..0 stored, reserved unchangeable
                nxt_pin_data = {`FSP_RSV_ONES, pwdata[4:0]};
            end
        end
    end

    // register storage
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_direction_ff <= `FSP_DIR_RST_HIGH;
            pin_data_ff      <= `FSP_DATA_RST;
        end else begin
            pin_direction_ff <= nxt_pin_direction;
            pin_data_ff      <= nxt_pin_data;
        end
    end

    // read data and error answer
    always @* begin
        nxt_prdata  = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (hw_stby_sync) begin
            nxt_pslverr = 1'b1;
        end else if (hit_dir) begin
            if (!pwrite) begin
                nxt_prdata = {24'h00_0000, `FSP_DIR_READ};
            end
        end else if (hit_data) begin
            if (!pwrite) begin
                nxt_prdata = {24'h00_0000, data_read};
            end
        end else begin
            nxt_pslverr = 1'b1;
        end
    end

    // apb answer flops, pready high one cycle after the access phase opens
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access) begin
            pready  <= 1'b1;
            prdata  <= nxt_prdata;
            pslverr <= nxt_pslverr;
        end else begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // pin function select per mode
    always @* begin
        nxt_pin_out = 5'h1f;
        nxt_pin_oe  = 5'h00;
        for (i = 0; i < `FSP_PINS; i = i + 1) begin
            // driver enabled only when direction bit is one
            nxt_pin_oe[i]  = pin_direction_ff[i];
            nxt_pin_out[i] = pin_data_ff[i];
        end
        if (expanded) begin
            // pin 4 area select 0, pins 3..1 area selects 3..1
            nxt_pin_out[4] = area_select_n[0];
            nxt_pin_out[3] = area_select_n[3];
            nxt_pin_out[2] = area_select_n[2];
            nxt_pin_out[1] = area_select_n[1];
            // pin 0 plain output unless refresh strobe selected
            if (refresh_enable) begin
                nxt_pin_out[0] = refresh_strobe_n;
            end
        end
        if (!init_done_ff || hw_stby_sync) begin
            // drivers off until mode known and in hardware standby
            nxt_pin_oe  = 5'h00;
            nxt_pin_out = 5'h1f;
        end
    end

    // pin drivers held in software standby, hardware standby still releases
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_out <= 5'h1f;
            pin_oe  <= 5'h00;
        end else if (hw_stby_sync || !sw_stby_sync) begin
            pin_out <= nxt_pin_out;
            pin_oe  <= nxt_pin_oe;
        end
    end
endmodule // fsp_port

// ---- fsp_pin_partner.sv ----
`timescale 1ns/100ps
// outside world at the pins: a source that drives where the port lets go
module fsp_pin_partner (
    input  wire [4:0] pin_out,
    input  wire [4:0] pin_oe,
    input  wire [4:0] ext_level,
    output wire [4:0] pin_in
);
    // port drive wins where enabled, else the external source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // fsp_pin_partner

// ---- fsp_port_properties.sv ----
`timescale 1ns/100ps
`include "fsp_port_map.vh"
// apb answers and pin drive of the port
module fsp_port_properties (
    input wire        mclk,
    input wire        reset,
    input wire [2:0]  mode,
    input wire        hw_standby,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [4:0]  pin_out,
    input wire [4:0]  pin_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // completed good reads and writes
    wire rd_ok  = pready && !pslverr && !pwrite;
    wire wr_ok  = psel && penable && pready && pwrite && !pslverr;
    wire at_dat = paddr == `FSP_ADDR_DATA;
    wire at_dir = paddr == `FSP_ADDR_DIR;
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_dir_ones: assert property (rd_ok && at_dir |-> prdata == 32'h0000_00ff)
        else $error("direction read not ones");
    a_rsv_ones: assert property (rd_ok && at_dat |-> prdata[31:5] == 27'h000_0007)
        else $error("reserved data bits wrong");
    a_read_mix: assert property (rd_ok && at_dat && mode >= 3'h6 |->
        ((prdata[4:0] ^ pin_out) & pin_oe) == 5'h00)
        else $error("output bit read wrong");
    a_oe_follow: assert property (wr_ok && at_dir |-> ##2 pin_oe == 5'($past(pwdata, 2)))
        else $error("enable not direction");
    a_sc_drive: assert property (wr_ok && at_dat && mode >= 3'h6 |->
        ##2 pin_out == 5'($past(pwdata, 2)))
        else $error("pin not data");
    a_unmapped: assert property (pready && !at_dir && !at_dat |-> pslverr && prdata == 0)
        else $error("unmapped not refused");
    a_hw_release: assert property (hw_standby [*8] |-> pin_oe == 5'h00)
        else $error("standby still driving");
endmodule // fsp_port_properties

bind fsp_port fsp_port_properties u_props (.mclk, .reset, .mode, .hw_standby, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_out, .pin_oe);

// ---- fsp_port_tb.sv ----
`timescale 1ns/100ps
`include "fsp_port_map.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module fsp_port_tb;
    logic        mclk = 1'b0, reset = 1'b1, hw_standby = 1'b0, sw_standby = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [2:0]  mode = 3'h6;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic [3:0]  area_select_n = 4'ha;
    logic        refresh_strobe_n = 1'b1, refresh_enable = 1'b0;
    logic [4:0]  ext_level = 5'h15;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    wire  [3:0]  ext_irq_request_n;
    wire  [4:0]  pin_in, pin_out, pin_oe;
    int          mismatches = 0, checked = 0, cycles = 0;

    fsp_port DUT (.mclk, .reset, .mode, .hw_standby, .sw_standby, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .area_select_n, .refresh_strobe_n,
        .refresh_enable, .ext_irq_request_n, .pin_in, .pin_out, .pin_oe);
    fsp_pin_partner u_partner (.pin_out, .pin_oe, .ext_level, .pin_in);

    // clock and hang guard
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task report_and_stop;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task rst(input logic [2:0] m);
        reset <= 1'b1;
        mode <= m;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask

    // one apb transfer, held until pready is sampled
    task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task t_reset_reads;
        rst(3'h6);
        `CHK("oe", 5'h00, pin_oe)
        apb(1'b0, `FSP_ADDR_DIR, 32'h0);
        `CHK("dir", 32'h0000_00ff, rd)
        apb(1'b0, `FSP_ADDR_DATA, 32'h0);
        `CHK("data", 32'h0000_00f5, rd)
        `CHK("irq", 4'h5, ext_irq_request_n)
    endtask

    task t_drive_standby;
        apb(1'b1, `FSP_ADDR_DIR, 32'h0000_001f);
        apb(1'b1, `FSP_ADDR_DATA, 32'h0000_000a);
        repeat (2) @(posedge mclk);
        `CHK("oe", 5'h1f, pin_oe)
        `CHK("out", 5'h0a, pin_out)
        apb(1'b0, `FSP_ADDR_DATA, 32'h0);
        `CHK("data", 32'h0000_00ea, rd)
        apb(1'b1, `FSP_ADDR_DIR, 32'h0000_0003);
        repeat (6) @(posedge mclk);
        apb(1'b0, `FSP_ADDR_DATA, 32'h0);
        `CHK("mix", 32'h0000_00f6, rd)
        sw_standby <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK("sw oe", 5'h03, pin_oe)
        `CHK("sw out", 5'h0a, pin_out)
        sw_standby <= 1'b0;
    endtask

    task t_refusals;
        apb(1'b0, 18'h3_ff38, 32'h0);
        `CHK("bad err", 1'b1, err)
        `CHK("bad data", 32'h0000_0000, rd)
        hw_standby <= 1'b1;
        repeat (8) @(posedge mclk);
        `CHK("hw oe", 5'h00, pin_oe)
        apb(1'b1, `FSP_ADDR_DATA, 32'h0000_001f);
        `CHK("hw err", 1'b1, err)
        hw_standby <= 1'b0;
        repeat (8) @(posedge mclk);
        apb(1'b1, `FSP_ADDR_DIR, 32'h0000_001f);
        apb(1'b0, `FSP_ADDR_DATA, 32'h0);
        `CHK("hw data", 32'h0000_00e0, rd)
    endtask

    task t_expanded;
        rst(3'h1);
        `CHK("x oe", 5'h10, pin_oe)
        `CHK("x sel", 1'b0, pin_out[4])
        apb(1'b1, `FSP_ADDR_DIR, 32'h0000_001f);
        apb(1'b1, `FSP_ADDR_DATA, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        `CHK("x out", 5'h0b, pin_out)
        refresh_enable <= 1'b1;
        refresh_strobe_n <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK("x refresh_strobe_n", 1'b0, pin_out[0])
        // software standby freezes the pins while the area selects move
        sw_standby <= 1'b1;
        repeat (6) @(posedge mclk);
        area_select_n <= 4'h5;
        repeat (2) @(posedge mclk);
        `CHK("x hold", 5'h0a, pin_out)
        sw_standby <= 1'b0;
        repeat (6) @(posedge mclk);
        `CHK("x free", 5'h14, pin_out)
    endtask

    task t_other_modes;
        rst(3'h5);
        `CHK("m5 oe", 5'h00, pin_oe)
        `CHK("m5 out", 5'h14, pin_out)
        refresh_strobe_n <= 1'b1;
        rst(3'h7);
        `CHK("m7 oe", 5'h00, pin_oe)
        `CHK("m7 out", 5'h00, pin_out)
    endtask

    initial begin
        t_reset_reads();
        t_drive_standby();
        t_refusals();
        t_expanded();
        t_other_modes();
        report_and_stop();
    end
endmodule // fsp_port_tb
